/* File: core/ehp_pkg.sv */
// shared constants and types for the encoder and host port front end
package ehp_pkg;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned POS_W        = 32;
   localparam int unsigned CLK_PERIOD_NS = 5;
   // encoder state must hold this many system clocks to count
   localparam int unsigned DWELL_CLKS   = 8;
   localparam int unsigned DWELL_W      = 4;
   localparam logic [DWELL_W-1:0] DWELL_LAST = 4'h7;
   // reset must be held this many clocks (far end's duty)
   localparam int unsigned RESET_CLKS   = 8;
   // host side cycle counts for strobe phases
   localparam int unsigned STROBE_CLKS  = 4;
   localparam logic [3:0]  STROBE_LAST  = 4'h3;
   localparam logic [DATA_W-1:0] BUSY_BIT_POS = 8'h00;
   localparam int unsigned BUSY_IDX     = 0;
   // busy stays set at least this many clocks after an access, then until busyDone
   localparam logic [3:0]  BUSY_CLKS    = 4'h8;
   localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   typedef enum logic {PORT_CMD, PORT_DATA} ehp_port_t;
   typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} ehp_op_t;
endpackage : ehp_pkg

/* File: core/ehp_if.sv */
// host bus and encoder pins between the front end and its host and encoder
`timescale 1ns/1ps
`default_nettype none
interface ehp_if;
   logic       chipSelN;
   logic       portSelect;
   logic       readN;
   logic       writeN;
   logic [7:0] hostBusToDev;
   logic [7:0] hostBusFromDev;
   logic       hostBusDevOeN;
   logic       hostBusHostOeN;
   logic       phaseA;
   logic       phaseB;
   logic       indexN;
   modport dev (
      input  chipSelN, portSelect, readN, writeN, hostBusToDev,
      input  phaseA, phaseB, indexN,
      output hostBusFromDev, hostBusDevOeN
   );
   modport host (
      output chipSelN, portSelect, readN, writeN, hostBusToDev, hostBusHostOeN,
      output phaseA, phaseB, indexN,
      input  hostBusFromDev, hostBusDevOeN
   );
endinterface : ehp_if
`default_nettype wire

/* File: core/ehp_device.sv */
// device end: quadrature decoder, index capture and host port
`timescale 1ns/1ps
`default_nettype none
module ehp_device
   import ehp_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   ehp_if.dev                           pins,
   input  wire logic [ehp_pkg::DATA_W-1:0] statusIn,
   input  wire logic [ehp_pkg::DATA_W-1:0] readData,
   input  wire logic                    busyDone,
   output logic      [ehp_pkg::DATA_W-1:0] cmdByte,
   output logic                         cmdStrobe,
   output logic      [ehp_pkg::DATA_W-1:0] wrData,
   output logic                         wrDataStrobe,
   output logic                         rdDataStrobe,
   output logic      [ehp_pkg::POS_W-1:0]  position,
   output logic      [ehp_pkg::POS_W-1:0]  indexPos,
   output logic                         indexStrobe,
   output logic                         busy
);
   import ehp_pkg::*;

   logic [2:0] syncA_q, sync2_q;
   logic [1:0] stable_q;
   logic [1:0] cand_q;
   logic [DWELL_W-1:0] dwell_q;
   logic idxStable_q;
   logic [POS_W-1:0] pos_q;
   logic [1:0] step;
   logic rdN_q, wrN_q, wrSel_q, rdSel_q;
   logic [DATA_W-1:0] busOut_q;
   logic busOeN_q;
   logic [3:0] busyCnt_q;

   // two-stage synchroniser, bit 0 is A, 1 is B, 2 is index
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         syncA_q <= 3'h7;
         sync2_q <= 3'h7;
      end
      else
      begin
         syncA_q <= {pins.indexN, pins.phaseB, pins.phaseA};
         sync2_q <= syncA_q;
      end
   end

   // dwell filter: a new state is accepted after it holds eight clocks
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cand_q      <= 2'h0;
         dwell_q     <= '0;
         stable_q    <= 2'h0;
         idxStable_q <= 1'b1;
      end
      else
      begin
         if (sync2_q[1:0] != cand_q)
         begin
            // the first sample of a new state already counts as one
            cand_q  <= sync2_q[1:0];
            dwell_q <= 4'h1;
         end
         else if (dwell_q != DWELL_LAST)
         begin
            dwell_q <= dwell_q + 1'b1;
         end
         else
         begin
            stable_q <= cand_q;
         end
         idxStable_q <= sync2_q[2];
      end
   end

   // gray sequence 00,01,11,10 forward with A as bit 0 leading
   logic [1:0] nextS;
   always_comb
   begin
      nextS = 2'h0;
      step  = 2'h0;
      if (dwell_q == DWELL_LAST && sync2_q[1:0] == cand_q && cand_q != stable_q)
      begin
         nextS = cand_q;
         case ({stable_q, nextS})
            4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00: step = 2'h1;
            4'b00_10, 4'b10_11, 4'b11_01, 4'b01_00: step = 2'h2;
            default: step = 2'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         pos_q <= POS_RESET;
      else if (step == 2'h1)
         pos_q <= pos_q + 1'b1;
      else if (step == 2'h2)
         pos_q <= pos_q - 1'b1;
   end
   assign position = pos_q;

   // index capture on the clock where index, A and B are all low
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         indexPos    <= POS_RESET;
         indexStrobe <= 1'b0;
      end
      else
      begin
         indexStrobe <= 1'b0;
         if (!idxStable_q && stable_q == 2'h0 && !indexStrobe)
         begin
            indexPos    <= pos_q;
            indexStrobe <= 1'b1;
         end
      end
   end

   // host strobe edge detection; a write completes on its rising edge
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdN_q   <= 1'b1;
         wrN_q   <= 1'b1;
         wrSel_q <= 1'b0;
         rdSel_q <= 1'b0;
      end
      else
      begin
         rdN_q   <= pins.readN | pins.chipSelN;
         wrN_q   <= pins.writeN | pins.chipSelN;
         wrSel_q <= pins.portSelect;
         rdSel_q <= pins.portSelect;
      end
   end

   logic wrEnd, rdEnd;
   assign wrEnd = !wrN_q && (pins.writeN | pins.chipSelN);
   assign rdEnd = !rdN_q && (pins.readN | pins.chipSelN);

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cmdByte      <= BYTE_ZERO;
         cmdStrobe    <= 1'b0;
         wrData       <= BYTE_ZERO;
         wrDataStrobe <= 1'b0;
         rdDataStrobe <= 1'b0;
      end
      else
      begin
         cmdStrobe    <= 1'b0;
         wrDataStrobe <= 1'b0;
         rdDataStrobe <= 1'b0;
         // live port select, so the first strobe cycle never takes a stale port
         if (!pins.writeN && !pins.chipSelN && !pins.portSelect)
            cmdByte <= pins.hostBusToDev;
         if (!pins.writeN && !pins.chipSelN && pins.portSelect)
            wrData <= pins.hostBusToDev;
         if (wrEnd && !wrSel_q)
            cmdStrobe <= 1'b1;
         if (wrEnd && wrSel_q)
            wrDataStrobe <= 1'b1;
         if (rdEnd && rdSel_q)
            rdDataStrobe <= 1'b1;
      end
   end

   // busy rises on the first clock of any command write or data access
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         busyCnt_q <= 4'h0;
      else if ((!pins.writeN || (!pins.readN && pins.portSelect)) && !pins.chipSelN)
         busyCnt_q <= BUSY_CLKS;
      else if (busyCnt_q != 4'h0)
         busyCnt_q <= busyCnt_q - 1'b1;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         busy <= 1'b0;
      else if ((!pins.writeN || (!pins.readN && pins.portSelect)) && !pins.chipSelN)
         busy <= 1'b1;
      else if (busyCnt_q == 4'h0 && busyDone)
         busy <= 1'b0;
   end

   // read driver: status on command port, data on data port
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busOut_q <= BYTE_ZERO;
         busOeN_q <= 1'b1;
      end
      else
      begin
         busOeN_q <= pins.readN | pins.chipSelN;
         if (pins.portSelect)
            busOut_q <= readData;
         else
         begin
            busOut_q <= statusIn;
            busOut_q[BUSY_IDX] <= busy | (!pins.writeN && !pins.chipSelN);
         end
      end
   end
   assign pins.hostBusFromDev = busOut_q;
   assign pins.hostBusDevOeN  = busOeN_q;
endmodule : ehp_device
`default_nettype wire

/* File: core/ehp_host.sv */
// host end: drives strobes on the host port and passes encoder pins through
`timescale 1ns/1ps
`default_nettype none
module ehp_host
   import ehp_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   ehp_if.host                          pins,
   input  wire logic                    reqValid,
   input  wire ehp_pkg::ehp_op_t        reqOp,
   input  wire logic                    reqPort,
   input  wire logic [ehp_pkg::DATA_W-1:0] reqData,
   output logic                         reqReady,
   output logic      [ehp_pkg::DATA_W-1:0] rspData,
   output logic                         rspValid,
   input  wire logic                    encA,
   input  wire logic                    encB,
   input  wire logic                    encIndexN,
   input  wire logic                    indexPresent,
   output logic                         devResetN
);
   import ehp_pkg::*;

   typedef enum logic [1:0] {S_RESET, S_IDLE, S_STROBE, S_RECOVER} ehp_hstate_t;
   ehp_hstate_t st_q;
   logic [3:0] cnt_q;
   logic       isRead_q;
   logic       csN_q, rdN_q, wrN_q, ps_q, oeN_q, a_q, b_q, ix_q;
   logic [DATA_W-1:0] dOut_q;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q      <= S_RESET;
         cnt_q     <= 4'h0;
         isRead_q  <= 1'b0;
         csN_q     <= 1'b1;
         rdN_q     <= 1'b1;
         wrN_q     <= 1'b1;
         ps_q      <= 1'b0;
         oeN_q     <= 1'b1;
         dOut_q    <= BYTE_ZERO;
         reqReady  <= 1'b0;
         rspValid  <= 1'b0;
         rspData   <= BYTE_ZERO;
         devResetN <= 1'b0;
      end
      else
      begin
         rspValid <= 1'b0;
         case (st_q)
            S_RESET:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == 4'(RESET_CLKS - 1))
               begin
                  devResetN <= 1'b1;
                  st_q      <= S_IDLE;
                  reqReady  <= 1'b1;
                  cnt_q     <= 4'h0;
               end
            end
            S_IDLE:
               if (reqValid && reqOp != OP_NONE)
               begin
                  reqReady <= 1'b0;
                  isRead_q <= (reqOp == OP_READ);
                  csN_q    <= 1'b0;
                  ps_q     <= reqPort;
                  rdN_q    <= !(reqOp == OP_READ);
                  wrN_q    <= !(reqOp == OP_WRITE);
                  oeN_q    <= !(reqOp == OP_WRITE);
                  dOut_q   <= reqData;
                  cnt_q    <= 4'h0;
                  st_q     <= S_STROBE;
               end
            S_STROBE:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == STROBE_LAST)
               begin
                  rdN_q <= 1'b1;
                  wrN_q <= 1'b1;
                  if (isRead_q)
                  begin
                     rspData  <= pins.hostBusFromDev;
                     rspValid <= 1'b1;
                  end
                  cnt_q <= 4'h0;
                  st_q  <= S_RECOVER;
               end
            end
            S_RECOVER:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == STROBE_LAST)
               begin
                  csN_q    <= 1'b1;
                  oeN_q    <= 1'b1;
                  reqReady <= 1'b1;
                  st_q     <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // encoder pins: index forced high when no index is fitted
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         a_q  <= 1'b0;
         b_q  <= 1'b0;
         ix_q <= 1'b1;
      end
      else
      begin
         a_q  <= encA;
         b_q  <= encB;
         ix_q <= indexPresent ? encIndexN : 1'b1;
      end
   end

   assign pins.chipSelN       = csN_q;
   assign pins.readN          = rdN_q;
   assign pins.writeN         = wrN_q;
   assign pins.portSelect     = ps_q;
   assign pins.hostBusToDev   = dOut_q;
   assign pins.hostBusHostOeN = oeN_q;
   assign pins.phaseA         = a_q;
   assign pins.phaseB         = b_q;
   assign pins.indexN         = ix_q;
endmodule : ehp_host
`default_nettype wire

/* File: dv/ehp_checker.sv */
// concurrent checks on the pins between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module ehp_checker (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic chipSelN,
   input wire logic portSelect,
   input wire logic readN,
   input wire logic writeN,
   input wire logic hostBusDevOeN,
   input wire logic hostBusHostOeN,
   input wire logic phaseA,
   input wire logic phaseB
);
   logic rdSel_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // selected read seen at the previous edge
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         rdSel_q <= 1'b0;
      else
         rdSel_q <= !chipSelN && !readN;
   end
   a_bus_no_clash: assert property (hostBusDevOeN || hostBusHostOeN)
      else $error("both ends drive the host bus");
   a_bus_release: assert property ((chipSelN || readN) && !rdSel_q |-> hostBusDevOeN)
      else $error("device drives bus outside a read");
   a_read_drive: assert property (!chipSelN && !readN && rdSel_q |-> !hostBusDevOeN)
      else $error("device not driving during read");
   a_strobe_select: assert property (!readN || !writeN |-> !chipSelN)
      else $error("strobe without chip select");
   a_write_width: assert property ($fell(writeN) |-> !writeN [*2])
      else $error("write strobe too short");
   a_port_steady: assert property (!readN && $stable(readN) |-> $stable(portSelect))
      else $error("port select moved during read");
   a_write_data: assert property (!writeN |-> readN && !hostBusHostOeN)
      else $error("host not driving a lone write");
   a_enc_dwell: assert property ($changed({phaseA, phaseB}) |=> $stable({phaseA, phaseB}) [*7])
      else $error("encoder state held too briefly");
   c_cmd_write: cover property ($fell(writeN) && !portSelect);
   c_data_read: cover property ($fell(readN) && portSelect);
   c_enc_move: cover property ($changed({phaseA, phaseB}));
endmodule : ehp_checker
`default_nettype wire

/* File: dv/tb_encoder_and_host_port_front_end.sv */
// self-checking bench: host end and device end joined across the pin interface
`timescale 1ns/1ps
`default_nettype none
module tb_encoder_and_host_port_front_end;
   import ehp_pkg::*;
   logic        ref_clk  = 1'b0;
   logic        resetn   = 1'b0;
   logic        reqValid = 1'b0;
   ehp_op_t     reqOp    = OP_NONE;
   logic        reqPort  = 1'b0;
   logic [7:0]  reqData  = 8'h00;
   logic        encA     = 1'b0;
   logic        encB     = 1'b0;
   logic        encIdxN  = 1'b1;
   logic        idxPresent = 1'b1;
   logic [7:0]  statusIn = 8'h84;
   logic [7:0]  readData = 8'h00;
   logic        busyDone = 1'b0;
   logic        devResetN, reqReady, rspValid, cmdStrobe, wrDataStrobe;
   logic        rdDataStrobe, indexStrobe, busy;
   logic [7:0]  rspData, cmdByte, wrData, gotRsp;
   logic [31:0] position, indexPos;
   int          err_total = 0;
   int          cmp_count = 0;
   int          expPos = 0;
   int          nCmd = 0, nWr = 0, nRd = 0, nIdx = 0;
   ehp_if pins ();
   always #2.5 ref_clk = ~ref_clk;
   ehp_host u_ehp_host (.ref_clk(ref_clk), .resetn(resetn), .pins(pins.host),
      .reqValid(reqValid), .reqOp(reqOp), .reqPort(reqPort), .reqData(reqData),
      .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid), .encA(encA),
      .encB(encB), .encIndexN(encIdxN), .indexPresent(idxPresent), .devResetN(devResetN));
   ehp_device u_ehp_device (.ref_clk(ref_clk), .resetn(devResetN), .pins(pins.dev),
      .statusIn(statusIn), .readData(readData), .busyDone(busyDone), .cmdByte(cmdByte),
      .cmdStrobe(cmdStrobe), .wrData(wrData), .wrDataStrobe(wrDataStrobe),
      .rdDataStrobe(rdDataStrobe), .position(position), .indexPos(indexPos),
      .indexStrobe(indexStrobe), .busy(busy));
   ehp_checker u_ehp_checker (.ref_clk(ref_clk), .resetn(resetn), .chipSelN(pins.chipSelN),
      .portSelect(pins.portSelect), .readN(pins.readN), .writeN(pins.writeN),
      .hostBusDevOeN(pins.hostBusDevOeN), .hostBusHostOeN(pins.hostBusHostOeN),
      .phaseA(pins.phaseA), .phaseB(pins.phaseB));
   // pulse counters so no single-cycle strobe is missed
   always @(posedge ref_clk)
   begin
      if (cmdStrobe) nCmd++;
      if (wrDataStrobe) nWr++;
      if (rdDataStrobe) nRd++;
      if (indexStrobe) nIdx++;
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic wait_for(input int which);
      int n;
      for (n = 0; n < 200; n++)
      begin
         @(posedge ref_clk);
         #1;
         if (which == 0 ? reqReady === 1'b1 : which == 1 ? rspValid === 1'b1 : busy === 1'b0)
            break;
      end
      if (n == 200)
      begin
         err_total++;
         wrap_up();
      end
   endtask : wait_for
   task automatic host_req(input ehp_op_t op, input logic port, input logic [7:0] d);
      wait_for(0);
      @(posedge ref_clk);
      reqValid <= 1'b1;
      reqOp <= op;
      reqPort <= port;
      reqData <= d;
      @(posedge ref_clk);
      reqValid <= 1'b0;
      if (op == OP_READ)
      begin
         wait_for(1);
         gotRsp = rspData;
      end
      wait_for(0);
   endtask : host_req
   task automatic step(input logic [1:0] ab, input int dpos);
      @(posedge ref_clk);
      encA <= ab[1];
      encB <= ab[0];
      repeat (16) @(posedge ref_clk);
      #1;
      expPos += dpos;
      cmp(position, 32'(expPos));
   endtask : step
   task automatic t_cmd;
      logic [7:0] v [3] = '{8'hA5, 8'h00, 8'hFF};
      int c;
      foreach (v[i])
      begin
         c = nCmd;
         host_req(OP_WRITE, 1'b0, v[i]);
         cmp(cmdByte, v[i]);
         cmp(nCmd - c, 1);
         cmp(busy, 1);
      end
      $display("test cmd done");
   endtask : t_cmd
   task automatic t_status;
      host_req(OP_READ, 1'b0, 8'h00);
      cmp(gotRsp, 8'h85);
      @(posedge ref_clk);
      busyDone <= 1'b1;
      wait_for(2);
      host_req(OP_READ, 1'b0, 8'h00);
      cmp(gotRsp, 8'h84);
      $display("test status done");
   endtask : t_status
   task automatic t_data;
      int c;
      c = nCmd;
      @(posedge ref_clk);
      readData <= 8'h5A;
      host_req(OP_READ, 1'b1, 8'h00);
      cmp(gotRsp, 8'h5A);
      cmp(nRd, 1);
      host_req(OP_WRITE, 1'b1, 8'h3C);
      cmp(wrData, 8'h3C);
      cmp(nWr, 1);
      cmp(nCmd - c, 0);
      $display("test data done");
   endtask : t_data
   task automatic t_encoder;
      int c;
      logic [1:0] fwd [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
      logic [1:0] rev [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
      foreach (fwd[i])
         step(fwd[i], 1);
      c = nIdx;
      @(posedge ref_clk);
      encIdxN <= 1'b0;
      repeat (16) @(posedge ref_clk);
      #1;
      cmp(nIdx > c, 1);
      cmp(indexPos, 32'h0000_0004);
      @(posedge ref_clk);
      encIdxN <= 1'b1;
      step(2'b10, 1);
      c = nIdx;
      @(posedge ref_clk);
      encIdxN <= 1'b0;
      repeat (16) @(posedge ref_clk);
      encIdxN <= 1'b1;
      #1;
      cmp(nIdx - c, 0);
      step(2'b00, -1);
      foreach (rev[i])
         step(rev[i], -1);
      step(2'b11, 0);
      step(2'b00, 0);
      // a state held for exactly the minimum dwell must still count
      @(posedge ref_clk);
      encA <= 1'b1;
      repeat (8) @(posedge ref_clk);
      encA <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      cmp(position, 32'(expPos + 1));
      repeat (16) @(posedge ref_clk);
      #1;
      cmp(position, 32'(expPos));
      // no index fitted: the pin is held high, so no capture at state 00
      c = nIdx;
      @(posedge ref_clk);
      idxPresent <= 1'b0;
      encIdxN    <= 1'b0;
      repeat (16) @(posedge ref_clk);
      idxPresent <= 1'b1;
      encIdxN    <= 1'b1;
      #1;
      cmp(nIdx - c, 0);
      $display("test encoder done");
   endtask : t_encoder
   initial
   begin
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      t_cmd();
      t_status();
      t_data();
      t_encoder();
      wrap_up();
   end
endmodule : tb_encoder_and_host_port_front_end
`default_nettype wire
